//--- src/gpio_ctrl_pkg.sv
// constants for the dual i/o port control block
package gpio_ctrl_pkg;

	// port width and bus widths
	localparam int unsigned PORT_W     = 8;
	localparam int unsigned ADDR_W     = 16;
	localparam int unsigned DATA_W     = 32;
	localparam int unsigned SYNC_DEPTH = 3;

	// register indices; byte address is four times the index
	localparam logic [15:0] IDX_P4_LATCH    = 16'h0004;
	localparam logic [15:0] IDX_P7_LATCH    = 16'h0007;
	localparam logic [15:0] IDX_P4_PIN_READ = 16'h0011;
	localparam logic [15:0] IDX_P4_DIR      = 16'h0F1E;
	localparam logic [15:0] IDX_P7_DIR      = 16'h0F21;
	localparam logic [15:0] IDX_P4_PULLUP   = 16'h0F2B;
	localparam logic [15:0] IDX_P4_FUNC     = 16'h0F38;
	localparam logic [15:0] IDX_P7_FUNC     = 16'h0F3B;

	// reset values
	localparam logic [7:0] RST_P4_LATCH  = 8'h00;
	localparam logic [7:0] RST_P7_LATCH  = 8'h00;
	localparam logic [7:0] RST_P4_DIR    = 8'h00;
	localparam logic [7:0] RST_P7_DIR    = 8'h00;
	localparam logic [7:0] RST_P4_PULLUP = 8'h00;
	localparam logic [7:0] RST_P4_FUNC   = 8'h00;
	localparam logic [7:0] RST_P7_FUNC   = 8'h00;

	// writable bits of the second port function select
	localparam logic [7:0] P7_FUNC_MASK = 8'h1F;

	// second port field positions
	localparam int unsigned P7_INT_LSB  = 5;
	localparam int unsigned P7_DIV_BIT  = 4;
	localparam int unsigned P7_TCA_LSB  = 2;
	localparam int unsigned P7_PPGA_LSB = 2;
	localparam int unsigned P7_TC_LSB   = 0;
	localparam int unsigned P7_PPG_LSB  = 0;

	// response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

//--- src/gpio_pin_sync.sv
// three-stage pin synchroniser, change accepted when stages two and three agree
`timescale 1ns/1ps

module gpio_pin_sync #(
	parameter int unsigned WIDTH = 8
) (
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst,
	// pins and settled value
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	if (WIDTH < 1) begin : g_chk
		$error("gpio_pin_sync: WIDTH must be at least 1");
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
			dout   <= '0;
		end else begin
			stage1 <= din;
			stage2 <= stage1;
			stage3 <= stage2;
			dout   <= (stage2 & stage3) | (dout & (stage2 ^ stage3));
		end
	end

endmodule

//--- src/dual_port_io_control.sv
// register file and pin logic for two eight-bit general-purpose ports
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps

module dual_port_io_control #(
	parameter int unsigned PORT_WIDTH = gpio_ctrl_pkg::PORT_W
) (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// axi4-lite write address
	input  wire logic [15:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read address
	input  wire logic [15:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// axi4-lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// first port pins
	input  wire logic [7:0]  port4_pin_in,
	output logic      [7:0]  port4_pin_out,
	output logic      [7:0]  port4_pin_oe,
	output logic      [7:0]  port4_pullup_on,
	// first port secondary functions
	output logic      [7:0]  analog_input_channel,
	input  wire logic [7:0]  key_wakeup_enable_bit,
	// second port pins
	input  wire logic [7:0]  port7_pin_in,
	output logic      [7:0]  port7_pin_out,
	output logic      [7:0]  port7_pin_oe,
	// second port peripheral outputs toward pins
	input  wire logic        divider_output,
	input  wire logic [1:0]  pulse_gen_a_output,
	input  wire logic [1:0]  pulse_gen_output,
	// second port pin inputs toward peripherals
	output logic      [2:0]  external_interrupt_line,
	output logic      [1:0]  timer_a_input,
	output logic      [1:0]  timer_input
);

	if (PORT_WIDTH != 8) begin : g_chk
		$error("dual_port_io_control: PORT_WIDTH must be 8");
	end

	// byte address of a register index
	function automatic logic hit(input logic [15:0] addr, input logic [15:0] idx);
		hit = (addr == {idx[13:0], 2'b00});
	endfunction

	// control registers
	logic [7:0] port4_output_latch;
	logic [7:0] port4_direction;
	logic [7:0] port4_pullup_enable;
	logic [7:0] port4_function_select;
	logic [7:0] port7_output_latch;
	logic [7:0] port7_direction;
	logic [7:0] port7_function_select;

	// synchronised pins
	logic [7:0] p4_pin_sync;
	logic [7:0] p7_pin_sync;

	// write channel state
	logic        aw_held;
	logic        w_held;
	logic [15:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;

	gpio_pin_sync #(
		.WIDTH (8)
	) u_sync4 (
		.core_clk (core_clk),
		.rst      (rst),
		.din      (port4_pin_in),
		.dout     (p4_pin_sync)
	);

	gpio_pin_sync #(
		.WIDTH (8)
	) u_sync7 (
		.core_clk (core_clk),
		.rst      (rst),
		.din      (port7_pin_in),
		.dout     (p7_pin_sync)
	);

	// ---------------- write path ----------------
	wire aw_fire  = s_axi_awvalid & s_axi_awready;
	wire w_fire   = s_axi_wvalid & s_axi_wready;
	wire do_write = aw_held & w_held & ~s_axi_bvalid;
	wire lane0    = w_strb[0];

	wire ws_p4_latch = hit(aw_addr, gpio_ctrl_pkg::IDX_P4_LATCH);
	wire ws_p7_latch = hit(aw_addr, gpio_ctrl_pkg::IDX_P7_LATCH);
	wire ws_p4_pread = hit(aw_addr, gpio_ctrl_pkg::IDX_P4_PIN_READ);
	wire ws_p4_dir   = hit(aw_addr, gpio_ctrl_pkg::IDX_P4_DIR);
	wire ws_p7_dir   = hit(aw_addr, gpio_ctrl_pkg::IDX_P7_DIR);
	wire ws_p4_pu    = hit(aw_addr, gpio_ctrl_pkg::IDX_P4_PULLUP);
	wire ws_p4_func  = hit(aw_addr, gpio_ctrl_pkg::IDX_P4_FUNC);
	wire ws_p7_func  = hit(aw_addr, gpio_ctrl_pkg::IDX_P7_FUNC);

	wire ws_rw = ws_p4_latch | ws_p7_latch | ws_p4_dir | ws_p7_dir
		| ws_p4_pu | ws_p4_func | ws_p7_func;

	wire [1:0] next_bresp = ws_rw ? gpio_ctrl_pkg::RESP_OKAY
		: (ws_p4_pread ? gpio_ctrl_pkg::RESP_SLVERR : gpio_ctrl_pkg::RESP_DECERR);

	wire we   = do_write & lane0;
	wire [7:0] wbyte = w_data[7:0];

	assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_held & ~s_axi_bvalid;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			aw_held <= 1'b0;
			aw_addr <= 16'h0000;
		end else if (aw_fire) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			w_held <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else if (w_fire) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= gpio_ctrl_pkg::RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= next_bresp;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// register updates land at the write edge
	always_ff @(posedge core_clk) begin
		if (rst) begin
			port4_output_latch    <= gpio_ctrl_pkg::RST_P4_LATCH;
			port4_direction       <= gpio_ctrl_pkg::RST_P4_DIR;
			port4_pullup_enable   <= gpio_ctrl_pkg::RST_P4_PULLUP;
			port4_function_select <= gpio_ctrl_pkg::RST_P4_FUNC;
			port7_output_latch    <= gpio_ctrl_pkg::RST_P7_LATCH;
			port7_direction       <= gpio_ctrl_pkg::RST_P7_DIR;
			port7_function_select <= gpio_ctrl_pkg::RST_P7_FUNC;
		end else if (we) begin
			if (ws_p4_latch) begin
				port4_output_latch <= wbyte;
			end
			if (ws_p4_dir) begin
				port4_direction <= wbyte;
			end
			if (ws_p4_pu) begin
				port4_pullup_enable <= wbyte;
			end
			if (ws_p4_func) begin
				port4_function_select <= wbyte;
			end
			if (ws_p7_latch) begin
				port7_output_latch <= wbyte;
			end
			if (ws_p7_dir) begin
				port7_direction <= wbyte;
			end
			if (ws_p7_func) begin
				port7_function_select <= wbyte & gpio_ctrl_pkg::P7_FUNC_MASK;
			end
		end
	end

	// ---------------- read path ----------------
	wire ar_fire = s_axi_arvalid & s_axi_arready;

	wire rs_p4_latch = hit(s_axi_araddr, gpio_ctrl_pkg::IDX_P4_LATCH);
	wire rs_p7_latch = hit(s_axi_araddr, gpio_ctrl_pkg::IDX_P7_LATCH);
	wire rs_p4_pread = hit(s_axi_araddr, gpio_ctrl_pkg::IDX_P4_PIN_READ);
	wire rs_p4_dir   = hit(s_axi_araddr, gpio_ctrl_pkg::IDX_P4_DIR);
	wire rs_p7_dir   = hit(s_axi_araddr, gpio_ctrl_pkg::IDX_P7_DIR);
	wire rs_p4_pu    = hit(s_axi_araddr, gpio_ctrl_pkg::IDX_P4_PULLUP);
	wire rs_p4_func  = hit(s_axi_araddr, gpio_ctrl_pkg::IDX_P4_FUNC);
	wire rs_p7_func  = hit(s_axi_araddr, gpio_ctrl_pkg::IDX_P7_FUNC);

	wire rs_any = rs_p4_latch | rs_p7_latch | rs_p4_pread | rs_p4_dir
		| rs_p7_dir | rs_p4_pu | rs_p4_func | rs_p7_func;

	// live level only for a plain input bit
	wire [7:0] p4_pin_read_val = p4_pin_sync & ~port4_direction
		& ~port4_function_select;

	wire [7:0] rd_byte =
		  ({8{rs_p4_latch}} & port4_output_latch)
		| ({8{rs_p7_latch}} & port7_output_latch)
		| ({8{rs_p4_pread}} & p4_pin_read_val)
		| ({8{rs_p4_dir}}   & port4_direction)
		| ({8{rs_p7_dir}}   & port7_direction)
		| ({8{rs_p4_pu}}    & port4_pullup_enable)
		| ({8{rs_p4_func}}  & port4_function_select)
		| ({8{rs_p7_func}}  & port7_function_select);

	wire [1:0] next_rresp = rs_any ? gpio_ctrl_pkg::RESP_OKAY
		: gpio_ctrl_pkg::RESP_DECERR;

	assign s_axi_arready = ~s_axi_rvalid;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= gpio_ctrl_pkg::RESP_OKAY;
		end else if (ar_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {24'h00_0000, rd_byte};
			s_axi_rresp  <= next_rresp;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ---------------- first port pins ----------------
	// a pin with wakeup enabled is an input whatever the direction bit says
	wire [7:0] p4_input_mode = ~port4_direction | key_wakeup_enable_bit;

	wire [7:0] next_p4_oe = ~p4_input_mode & ~port4_function_select;

	wire [7:0] next_p4_pull = port4_pullup_enable & p4_input_mode;

	// ---------------- second port pins ----------------
	wire [7:0] p7_periph_out;
	wire [7:0] next_p7_out;

	assign p7_periph_out[7:gpio_ctrl_pkg::P7_INT_LSB] = 3'b000;
	assign p7_periph_out[gpio_ctrl_pkg::P7_DIV_BIT]   = divider_output;
	assign p7_periph_out[gpio_ctrl_pkg::P7_PPGA_LSB +: 2] = pulse_gen_a_output;
	assign p7_periph_out[gpio_ctrl_pkg::P7_PPG_LSB +: 2]  = pulse_gen_output;

	// per-bit choice of latch or peripheral drive
	for (genvar b = 0; b < 8; b++) begin : g_p7_mux
		assign next_p7_out[b] = port7_function_select[b]
			? p7_periph_out[b] : port7_output_latch[b];
	end

	// secondary inputs see the pin only in input mode
	wire [7:0] p7_in_seen = p7_pin_sync & ~port7_direction;

	// pin drivers follow the registers one edge later
	always_ff @(posedge core_clk) begin
		if (rst) begin
			port4_pin_out        <= 8'h00;
			port4_pin_oe         <= 8'h00;
			port4_pullup_on      <= 8'h00;
			analog_input_channel <= 8'h00;
		end else begin
			port4_pin_out        <= port4_output_latch;
			port4_pin_oe         <= next_p4_oe;
			port4_pullup_on      <= next_p4_pull;
			analog_input_channel <= port4_function_select;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			port7_pin_out <= 8'h00;
			port7_pin_oe  <= 8'h00;
		end else begin
			port7_pin_out <= next_p7_out;
			port7_pin_oe  <= port7_direction;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			external_interrupt_line <= 3'b000;
			timer_a_input           <= 2'b00;
			timer_input             <= 2'b00;
		end else begin
			external_interrupt_line <= p7_in_seen[gpio_ctrl_pkg::P7_INT_LSB +: 3];
			timer_a_input           <= p7_in_seen[gpio_ctrl_pkg::P7_TCA_LSB +: 2];
			timer_input             <= p7_in_seen[gpio_ctrl_pkg::P7_TC_LSB +: 2];
		end
	end

endmodule

//--- dv/dual_port_io_control_monitor.sv
// assertion checker for the dual port i/o control block
`timescale 1ns/1ps

module dual_port_io_control_monitor (
	// clock and reset
	input wire logic        core_clk,
	input wire logic        rst,
	// register bus
	input wire logic [15:0] s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// first port pins
	input wire logic [7:0]  port4_pin_oe,
	input wire logic [7:0]  port4_pullup_on,
	input wire logic [7:0]  analog_input_channel
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff rst;

	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_slverr;
		s_axi_bvalid && s_axi_bresp == gpio_ctrl_pkg::RESP_SLVERR;
	endsequence

	property p_analog_off;
		(port4_pin_oe & analog_input_channel) == 8'h00;
	endproperty
	a_analog_off: assert property (p_analog_off) else $error("driver on for analog pin");
	property p_pullup_in;
		(port4_pullup_on & port4_pin_oe) == 8'h00;
	endproperty
	a_pullup_in: assert property (p_pullup_in) else $error("pull-up on while driving");
	property p_ro_write;
		s_wr_taken ##0 s_axi_awaddr == 16'h0044 |-> ##2 s_slverr;
	endproperty
	a_ro_write: assert property (p_ro_write) else $error("pin-read write not refused");
	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped");
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read data dropped");
	property p_rlat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rlat: assert property (p_rlat) else $error("read answer late");
	property p_rhigh;
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000 && !s_axi_arready;
	endproperty
	a_rhigh: assert property (p_rhigh) else $error("read upper bits or arready wrong");
	property p_wbusy;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_wbusy: assert property (p_wbusy) else $error("write taken while response pending");
endmodule

bind dual_port_io_control dual_port_io_control_monitor mon (.core_clk, .rst, .s_axi_awaddr,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
	.port4_pin_oe, .port4_pullup_on, .analog_input_channel);

//--- dv/io_pin_world.sv
// model of the pins and peripherals around the i/o control block
`timescale 1ns/1ps

module io_pin_world (
	// clock
	input  wire logic       core_clk,
	// first port
	input  wire logic [7:0] p4_out,
	input  wire logic [7:0] p4_oe,
	input  wire logic [7:0] p4_pu,
	input  wire logic [7:0] ext4,
	input  wire logic [7:0] ext4_drv,
	// second port
	input  wire logic [7:0] p7_out,
	input  wire logic [7:0] p7_oe,
	input  wire logic [7:0] ext7,
	input  wire logic [4:0] periph,
	// levels seen by the device
	output logic      [7:0] p4_pin,
	output logic      [7:0] p7_pin,
	output logic            div_out,
	output logic      [1:0] pga_out,
	output logic      [1:0] pg_out
);
	logic [7:0] noise = 8'h5A;

	// an undriven pin without pull-up wanders every cycle
	always_ff @(posedge core_clk) noise <= ~noise;
	// device driver wins, pull-up only acts on a released pin
	assign p4_pin = (p4_oe & p4_out) | (~p4_oe & ext4_drv & ext4)
		| (~p4_oe & ~ext4_drv & (p4_pu | noise));
	assign p7_pin = (p7_oe & p7_out) | (~p7_oe & ext7);
	assign {div_out, pga_out, pg_out} = periph;
endmodule

//--- dv/dual_port_io_control_test.sv
// self-checking bench for the dual port i/o control block
`timescale 1ns/1ps

module dual_port_io_control_test;
	logic [15:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, pulse_gen_a_output, pulse_gen_output;
	logic [1:0]  timer_a_input, timer_input;
	logic        core_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, divider_output;
	logic [7:0]  port4_pin_in, port4_pin_out, port4_pin_oe, port4_pullup_on, analog_input_channel;
	logic [7:0]  key_wakeup_enable_bit, port7_pin_in, port7_pin_out, port7_pin_oe;
	logic [7:0]  ext4, ext4_drv, ext7;
	logic [4:0]  periph;
	logic [2:0]  external_interrupt_line;
	int          mismatches, cmp_count, cyc;
	localparam logic [15:0] REGS [7] = '{gpio_ctrl_pkg::IDX_P4_LATCH, gpio_ctrl_pkg::IDX_P7_LATCH,
		gpio_ctrl_pkg::IDX_P4_DIR, gpio_ctrl_pkg::IDX_P7_DIR, gpio_ctrl_pkg::IDX_P4_PULLUP,
		gpio_ctrl_pkg::IDX_P4_FUNC, gpio_ctrl_pkg::IDX_P7_FUNC};

	dual_port_io_control dut (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .port4_pin_in, .port4_pin_out, .port4_pin_oe,
		.port4_pullup_on, .analog_input_channel, .key_wakeup_enable_bit, .port7_pin_in,
		.port7_pin_out, .port7_pin_oe, .divider_output, .pulse_gen_a_output, .pulse_gen_output,
		.external_interrupt_line, .timer_a_input, .timer_input);
	io_pin_world world (.core_clk, .p4_out(port4_pin_out), .p4_oe(port4_pin_oe),
		.p4_pu(port4_pullup_on), .ext4, .ext4_drv, .p7_out(port7_pin_out), .p7_oe(port7_pin_oe),
		.ext7, .periph, .p4_pin(port4_pin_in), .p7_pin(port7_pin_in), .div_out(divider_output),
		.pga_out(pulse_gen_a_output), .pg_out(pulse_gen_output));

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
		logic ah, wh;
		ah = 1'h0;
		wh = 1'h0;
		@(posedge core_clk);
		s_axi_awaddr  <= idx << 2;
		s_axi_wdata   <= {24'h000000, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid  <= 1'h1;
		s_axi_bready  <= 1'h1;
		do begin
			@(posedge core_clk);
			if (s_axi_awvalid && s_axi_awready) begin
				ah = 1'h1;
				s_axi_awvalid <= 1'h0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wh = 1'h1;
				s_axi_wvalid <= 1'h0;
			end
		end while (!(ah && wh));
		while (!s_axi_bvalid) @(posedge core_clk);
		s_axi_bready <= 1'h0;
		chk({30'h0, s_axi_bresp}, {30'h0, er});
	endtask
	task automatic rdc(input logic [15:0] idx, input logic [7:0] ed, input logic [1:0] er);
		@(posedge core_clk);
		s_axi_araddr  <= idx << 2;
		s_axi_arvalid <= 1'h1;
		s_axi_rready  <= 1'h1;
		do @(posedge core_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		while (!s_axi_rvalid) @(posedge core_clk);
		s_axi_rready <= 1'h0;
		chk(s_axi_rdata, {24'h000000, ed});
		chk({30'h0, s_axi_rresp}, {30'h0, er});
	endtask

	task automatic t_regs;
		for (int i = 0; i < 7; i++)
			rdc(REGS[i], 8'h00, gpio_ctrl_pkg::RESP_OKAY);
		for (int i = 0; i < 7; i++) begin
			wr(REGS[i], 8'hA5 ^ 8'(i), gpio_ctrl_pkg::RESP_OKAY);
			rdc(REGS[i], (8'hA5 ^ 8'(i)) & (i == 6 ? 8'h1F : 8'hFF), 2'h0);
		end
		wr(16'h0100, 8'hFF, gpio_ctrl_pkg::RESP_DECERR);
		rdc(16'h0100, 8'h00, gpio_ctrl_pkg::RESP_DECERR);
		wr(gpio_ctrl_pkg::IDX_P4_PIN_READ, 8'hFF, gpio_ctrl_pkg::RESP_SLVERR);
	endtask
	task automatic t_port4;
		wr(gpio_ctrl_pkg::IDX_P4_DIR, 8'h33, 2'h0);
		wr(gpio_ctrl_pkg::IDX_P4_FUNC, 8'h50, 2'h0);
		wr(gpio_ctrl_pkg::IDX_P4_PULLUP, 8'hFF, 2'h0);
		wr(gpio_ctrl_pkg::IDX_P4_LATCH, 8'h55, 2'h0);
		@(posedge core_clk);
		ext4_drv <= 8'hDC;
		ext4     <= 8'hA5;
		repeat (6) @(posedge core_clk);
		chk(port4_pin_oe, 8'h23);
		chk(port4_pin_out & port4_pin_oe, 8'h01);
		chk(analog_input_channel, 8'h50);
		chk(port4_pullup_on, 8'hCC);
		rdc(gpio_ctrl_pkg::IDX_P4_PIN_READ, 8'h84, 2'h0);
		key_wakeup_enable_bit <= 8'h01;
		repeat (3) @(posedge core_clk);
		chk(port4_pin_oe, 8'h22);
		chk(port4_pullup_on, 8'hCD);
	endtask
	task automatic t_port7;
		wr(gpio_ctrl_pkg::IDX_P7_FUNC, 8'h00, 2'h0);
		wr(gpio_ctrl_pkg::IDX_P7_LATCH, 8'h0A, 2'h0);
		wr(gpio_ctrl_pkg::IDX_P7_DIR, 8'h1F, 2'h0);
		repeat (2) @(posedge core_clk);
		chk(port7_pin_oe, 8'h1F);
		chk(port7_pin_out & 8'h1F, 8'h0A);
		periph <= 5'h19;
		wr(gpio_ctrl_pkg::IDX_P7_FUNC, 8'h1F, 2'h0);
		repeat (2) @(posedge core_clk);
		chk(port7_pin_out & 8'h1F, 8'h19);
		ext7 <= 8'hA6;
		wr(gpio_ctrl_pkg::IDX_P7_DIR, 8'h00, 2'h0);
		repeat (6) @(posedge core_clk);
		chk({external_interrupt_line, timer_a_input, timer_input}, 7'h56);
		wr(gpio_ctrl_pkg::IDX_P7_DIR, 8'hFF, 2'h0);
		repeat (4) @(posedge core_clk);
		chk({external_interrupt_line, timer_a_input, timer_input}, 7'h00);
	endtask

	// answers left waiting a few cycles must stand until taken
	task automatic t_late;
		@(posedge core_clk);
		s_axi_awaddr  <= gpio_ctrl_pkg::IDX_P7_LATCH << 2;
		s_axi_wdata   <= 32'h0000_0033;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid  <= 1'h1;
		do @(posedge core_clk); while (!(s_axi_awready && s_axi_wready));
		s_axi_awvalid <= 1'h0;
		s_axi_wvalid  <= 1'h0;
		repeat (3) @(posedge core_clk);
		s_axi_bready <= 1'h1;
		do @(posedge core_clk); while (!s_axi_bvalid);
		s_axi_bready <= 1'h0;
		chk({30'h0, s_axi_bresp}, {30'h0, gpio_ctrl_pkg::RESP_OKAY});
		s_axi_araddr  <= gpio_ctrl_pkg::IDX_P7_LATCH << 2;
		s_axi_arvalid <= 1'h1;
		do @(posedge core_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		repeat (3) @(posedge core_clk);
		s_axi_rready <= 1'h1;
		do @(posedge core_clk); while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
		chk(s_axi_rdata, 32'h0000_0033);
	endtask

	initial begin
		core_clk = 1'h0;
		forever #50 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			give_verdict;
		end
	end
	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready, ext4, ext4_drv, ext7, periph} = '0;
		key_wakeup_enable_bit = 8'h00;
		s_axi_wstrb = 4'hF;
		rst = 1'h1;
		repeat (20) @(posedge core_clk);
		rst <= 1'h0;
		t_regs;
		t_port4;
		t_port7;
		t_late;
		give_verdict;
	end
endmodule
